// *** sdir_pkg.sv ***
package sdir_pkg;

    localparam int SDIR_WORD_W = 12;
    localparam int SDIR_MAG_W = 11;
    localparam int SDIR_PIN_N = 8;

    // positions of the pins in the sampled pin vector
    localparam int SDIR_PIN_DATA = 0;
    localparam int SDIR_PIN_RISE_A = 1;
    localparam int SDIR_PIN_RISE_B = 2;
    localparam int SDIR_PIN_FALL_N = 3;
    localparam int SDIR_PIN_RISE_C = 4;
    localparam int SDIR_PIN_LOAD_A_N = 5;
    localparam int SDIR_PIN_LOAD_B_N = 6;
    localparam int SDIR_PIN_ZERO_N = 7;

    // idle level of every pin: strobes inactive, loads high, clear high
    localparam logic [7:0] SDIR_PIN_IDLE = 8'hE8;

    // register map, byte addresses on the slave port
    localparam int SDIR_ADDR_W = 4;
    localparam logic [3:0] SDIR_ADDR_CTRL = 4'h0;
    localparam logic [3:0] SDIR_ADDR_SHIFT = 4'h4;
    localparam logic [3:0] SDIR_ADDR_CODE = 4'h8;
    localparam logic [3:0] SDIR_ADDR_STATUS = 4'hC;

    // control bits
    localparam int SDIR_CTRL_SHIFT_EN = 0;
    localparam int SDIR_CTRL_LOAD_EN = 1;
    localparam logic [1:0] SDIR_CTRL_RESET = 2'h3;

    // status bits; 0 and 1 are write-one-to-clear, 2 and 3 live
    localparam int SDIR_ST_CONFLICT = 0;
    localparam int SDIR_ST_EARLY_LOAD = 1;
    localparam int SDIR_ST_CLEAR_LOW = 2;
    localparam int SDIR_ST_STALLED = 3;

    // shift register readback: fill count field position
    localparam int SDIR_SHIFT_COUNT_LSB = 16;
    localparam logic [3:0] SDIR_FULL_COUNT = 4'hC;

    typedef struct packed {
        logic [11:0] code;
        logic polarity;
        logic [10:0] magnitude;
    } sdir_dac_t;

    localparam sdir_dac_t SDIR_DAC_ZERO = 24'h000000;

    typedef struct packed {
        logic [11:0] data;
        logic valid;
    } sdir_word_t;

endpackage

// *** sdir_serial_dac_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdir_serial_dac_regs (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic serial_bit_in,
    input wire logic shift_strobe_rise_a,
    input wire logic shift_strobe_rise_b,
    input wire logic shift_strobe_fall_n,
    input wire logic shift_strobe_rise_c,
    input wire logic transfer_enable_a_n,
    input wire logic transfer_enable_b_n,
    input wire logic input_reg_zero_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [11:0] dac_code,
    output logic dac_polarity,
    output logic [10:0] dac_magnitude,
    output logic [11:0] code_out_data,
    output logic code_out_valid,
    input wire logic code_out_ready
);

    typedef struct packed {
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [7:0] prev;
        logic [11:0] shift_reg;
        logic [3:0] fill;
        logic load_seen;
        logic shift_en;
        logic load_en;
        logic conflict;
        logic early_load;
        logic stalled;
        logic bus_wait;
        logic [31:0] readdata;
        sdir_pkg::sdir_word_t head;
        sdir_pkg::sdir_word_t skid;
    } sdir_state_t;

    sdir_state_t s;
    sdir_state_t next_s;
    sdir_pkg::sdir_dac_t dac;
    sdir_pkg::sdir_dac_t next_dac;

    logic [7:0] pins_raw;
    logic [7:0] cur;
    logic [7:0] rise;
    logic [7:0] fall;
    logic hit_a;
    logic hit_b;
    logic hit_c;
    logic hit_f;
    logic shift_hit;
    logic any_edge;
    logic load_lvl;
    logic load_go;
    logic clr_rst_n;

    assign pins_raw = {input_reg_zero_n, transfer_enable_b_n, transfer_enable_a_n,
                       shift_strobe_rise_c, shift_strobe_fall_n, shift_strobe_rise_b,
                       shift_strobe_rise_a, serial_bit_in};

    // only the second stage and the edge history are ever looked at
    assign cur = s.sync2;
    assign rise = s.sync2 & ~s.prev;
    assign fall = ~s.sync2 & s.prev;

    // true when every strobe other than the one at idx is at its idle level
    function automatic logic sdir_others_idle(input logic [7:0] lvl, input int idx);
        logic ok;
        ok = 1'b1;
        for (int i = sdir_pkg::SDIR_PIN_RISE_A; i <= sdir_pkg::SDIR_PIN_RISE_C; i++) begin
            if (i != idx && lvl[i] != sdir_pkg::SDIR_PIN_IDLE[i]) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    assign hit_a = rise[sdir_pkg::SDIR_PIN_RISE_A]
                   && sdir_others_idle(cur, sdir_pkg::SDIR_PIN_RISE_A);
    assign hit_b = rise[sdir_pkg::SDIR_PIN_RISE_B]
                   && sdir_others_idle(cur, sdir_pkg::SDIR_PIN_RISE_B);
    assign hit_c = rise[sdir_pkg::SDIR_PIN_RISE_C]
                   && sdir_others_idle(cur, sdir_pkg::SDIR_PIN_RISE_C);
    assign hit_f = fall[sdir_pkg::SDIR_PIN_FALL_N]
                   && sdir_others_idle(cur, sdir_pkg::SDIR_PIN_FALL_N);
    assign shift_hit = (hit_a || hit_b || hit_c || hit_f) && s.shift_en;
    assign any_edge = rise[sdir_pkg::SDIR_PIN_RISE_A] || rise[sdir_pkg::SDIR_PIN_RISE_B]
                      || rise[sdir_pkg::SDIR_PIN_RISE_C] || fall[sdir_pkg::SDIR_PIN_FALL_N];

    // clear is also sampled so a pending load is not pushed while it is low
    assign load_lvl = !cur[sdir_pkg::SDIR_PIN_LOAD_A_N] && !cur[sdir_pkg::SDIR_PIN_LOAD_B_N]
                      && cur[sdir_pkg::SDIR_PIN_ZERO_N] && s.load_en;
    // a new load waits while the output buffer is full, so no word is dropped
    assign load_go = load_lvl && !s.load_seen && !s.skid.valid;

    always_comb begin
        next_s = s;
        next_dac = dac;
        next_s.sync1 = pins_raw;
        next_s.sync2 = s.sync1;
        next_s.prev = s.sync2;

        if (shift_hit) begin
            next_s.shift_reg = {s.shift_reg[10:0], cur[sdir_pkg::SDIR_PIN_DATA]};
            if (s.fill != sdir_pkg::SDIR_FULL_COUNT) begin
                next_s.fill = s.fill + 4'h1;
            end
        end

        if (!load_lvl) begin
            next_s.load_seen = 1'b0;
            next_s.stalled = 1'b0;
        end else if (load_go) begin
            next_s.load_seen = 1'b1;
            next_s.stalled = 1'b0;
            next_s.fill = 4'h0;
            next_dac.code = s.shift_reg;
        end else if (s.load_seen) begin
            // loads held low keep the register transparent, as on the pins
            next_dac.code = s.shift_reg;
        end else begin
            next_s.stalled = 1'b1;
        end
        next_dac.polarity = next_dac.code[11];
        next_dac.magnitude = next_dac.code[10:0];

        // two-entry skid buffer between transfers and the code stream
        if (s.head.valid && !code_out_ready) begin
            if (load_go) begin
                next_s.skid.data = s.shift_reg;
                next_s.skid.valid = 1'b1;
            end
        end else if (s.skid.valid) begin
            next_s.head = s.skid;
            next_s.skid.valid = 1'b0;
        end else begin
            next_s.head.data = s.shift_reg;
            next_s.head.valid = load_go;
        end

        // bus: one wait cycle, then the answer; writes land on the acked edge
        next_s.bus_wait = !((avs_read || avs_write) && s.bus_wait);
        if (avs_read && s.bus_wait) begin
            unique case (avs_address)
                sdir_pkg::SDIR_ADDR_CTRL: begin
                    next_s.readdata = {30'h00000000, s.load_en, s.shift_en};
                end
                sdir_pkg::SDIR_ADDR_SHIFT: begin
                    next_s.readdata = {12'h000, s.fill, 4'h0, s.shift_reg};
                end
                sdir_pkg::SDIR_ADDR_CODE: begin
                    next_s.readdata = {20'h00000, dac.code};
                end
                sdir_pkg::SDIR_ADDR_STATUS: begin
                    next_s.readdata = {28'h0000000, s.stalled, !cur[sdir_pkg::SDIR_PIN_ZERO_N],
                                       s.early_load, s.conflict};
                end
                default: begin
                    next_s.readdata = 32'h00000000;
                end
            endcase
        end

        if (avs_write && !s.bus_wait && avs_byteenable[0]) begin
            if (avs_address == sdir_pkg::SDIR_ADDR_CTRL) begin
                next_s.shift_en = avs_writedata[sdir_pkg::SDIR_CTRL_SHIFT_EN];
                next_s.load_en = avs_writedata[sdir_pkg::SDIR_CTRL_LOAD_EN];
            end
            if (avs_address == sdir_pkg::SDIR_ADDR_STATUS) begin
                if (avs_writedata[sdir_pkg::SDIR_ST_CONFLICT]) begin
                    next_s.conflict = 1'b0;
                end
                if (avs_writedata[sdir_pkg::SDIR_ST_EARLY_LOAD]) begin
                    next_s.early_load = 1'b0;
                end
            end
        end
        // hardware sets after the clear so a same-cycle event survives
        if (any_edge && !(hit_a || hit_b || hit_c || hit_f)) begin
            next_s.conflict = 1'b1;
        end
        if (load_go && s.fill != sdir_pkg::SDIR_FULL_COUNT) begin
            next_s.early_load = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{sync1: sdir_pkg::SDIR_PIN_IDLE, sync2: sdir_pkg::SDIR_PIN_IDLE,
                   prev: sdir_pkg::SDIR_PIN_IDLE, shift_reg: 12'h000, fill: 4'h0,
                   load_seen: 1'b0, shift_en: sdir_pkg::SDIR_CTRL_RESET[0],
                   load_en: sdir_pkg::SDIR_CTRL_RESET[1], conflict: 1'b0,
                   early_load: 1'b0, stalled: 1'b0, bus_wait: 1'b1,
                   readdata: 32'h00000000, head: 13'h0000, skid: 13'h0000};
        end else begin
            s <= next_s;
        end
    end

    // the clear pin acts straight on these flops; a glitch on it only zeroes the code
    assign clr_rst_n = rst_n && input_reg_zero_n;

    always_ff @(posedge core_clk or negedge clr_rst_n) begin
        if (!clr_rst_n) begin
            dac <= sdir_pkg::SDIR_DAC_ZERO;
        end else begin
            dac <= next_dac;
        end
    end

    assign avs_readdata = s.readdata;
    assign avs_waitrequest = s.bus_wait;
    assign dac_code = dac.code;
    assign dac_polarity = dac.polarity;
    assign dac_magnitude = dac.magnitude;
    assign code_out_data = s.head.data;
    assign code_out_valid = s.head.valid;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_rise_shift_in: assert property (hit_a && s.shift_en |=>
        s.shift_reg[0] == $past(cur[sdir_pkg::SDIR_PIN_DATA]))
        else $error("rising strobe did not shift the data bit in");

    a_fall_shift_in: assert property (hit_f && s.shift_en |=>
        s.shift_reg[0] == $past(cur[sdir_pkg::SDIR_PIN_DATA]) && s.fill != 4'h0)
        else $error("falling strobe did not shift the data bit in");

    a_busy_strobe_block: assert property (rise[sdir_pkg::SDIR_PIN_RISE_A]
        && cur[sdir_pkg::SDIR_PIN_RISE_B] |=> $stable(s.shift_reg) && s.conflict)
        else $error("edge shifted while another strobe was active");

    a_shift_hold: assert property (!any_edge |=> $stable(s.shift_reg))
        else $error("shift register changed without a strobe edge");

    a_msb_first_move: assert property (shift_hit |=>
        s.shift_reg[11:1] == $past(s.shift_reg[10:0]))
        else $error("shift register did not move toward the msb");

    a_load_copy: assert property (load_go && input_reg_zero_n ##1 input_reg_zero_n
        |-> dac_code == $past(s.shift_reg) ##1 code_out_valid || $past(s.head.valid))
        else $error("transfer did not copy the shift register");

    a_load_idle_keep: assert property (!load_lvl && !s.load_seen && input_reg_zero_n
        ##1 input_reg_zero_n |-> $stable(dac_code))
        else $error("input register changed without a transfer");

    a_clear_zero: assert property (!input_reg_zero_n |-> dac_code == 12'h000
        && !dac_polarity)
        else $error("clear low but input register not zero");

    a_clear_over_load: assert property (!input_reg_zero_n [*3] |-> !load_lvl
        && dac_code == 12'h000)
        else $error("load acted while clear was low");

    a_clear_keeps_shift: assert property (!input_reg_zero_n && !shift_hit
        |=> $stable(s.shift_reg))
        else $error("clear disturbed the shift register");

    a_code_fields: assert property ({dac_polarity, dac_magnitude} == dac_code)
        else $error("polarity or magnitude does not match the code");

    a_reload_keeps: assert property (load_go && !shift_hit |=>
        s.shift_reg == $past(s.shift_reg) && s.fill == 4'h0)
        else $error("transfer altered the shift register");

    a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("slave did not answer after one wait cycle");

    // flags, fill count, shift enable, transfer stall and follow, stream and bus glue
    a_conflict_flag: assert property (any_edge
        && !(hit_a || hit_b || hit_c || hit_f) |=> s.conflict)
        else $error("refused strobe edge did not raise the conflict flag");

    a_early_flag: assert property (load_go && s.fill != sdir_pkg::SDIR_FULL_COUNT
        |=> s.early_load)
        else $error("short word transfer did not raise the early flag");

    a_shift_off_hold: assert property (!s.shift_en |=> $stable(s.shift_reg))
        else $error("shift register moved while shifting was disabled");

    a_fill_count: assert property (shift_hit && !load_go
        && s.fill != sdir_pkg::SDIR_FULL_COUNT |=> s.fill == $past(s.fill) + 4'h1)
        else $error("fill count did not follow the shifted bits");

    a_fill_limit: assert property (s.fill <= sdir_pkg::SDIR_FULL_COUNT)
        else $error("fill count ran past a whole word");

    a_stall_keeps: assert property (load_lvl && !s.load_seen && s.skid.valid
        && input_reg_zero_n ##1 input_reg_zero_n |-> $stable(dac_code))
        else $error("input register changed while the transfer was stalled");

    a_load_follow: assert property (load_lvl && s.load_seen && input_reg_zero_n
        ##1 input_reg_zero_n |-> dac_code == $past(s.shift_reg))
        else $error("input register did not follow while both loads were low");

    a_stream_push: assert property (load_go && !s.head.valid && !s.skid.valid
        |=> code_out_valid && code_out_data == $past(s.shift_reg))
        else $error("transfer did not push its word into the stream");

    a_stream_hold: assert property (code_out_valid && !code_out_ready
        |=> code_out_valid && $stable(code_out_data))
        else $error("stream word changed before it was taken");

    a_ctrl_write: assert property (avs_write && !avs_waitrequest && avs_byteenable[0]
        && avs_address == sdir_pkg::SDIR_ADDR_CTRL
        |=> s.shift_en == $past(avs_writedata[sdir_pkg::SDIR_CTRL_SHIFT_EN]))
        else $error("control write did not land on the acknowledged edge");

    a_read_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("read data moved without a read request");

    a_clear_status: assert property (avs_read && avs_waitrequest
        && avs_address == sdir_pkg::SDIR_ADDR_STATUS && !cur[sdir_pkg::SDIR_PIN_ZERO_N]
        |=> avs_readdata[sdir_pkg::SDIR_ST_CLEAR_LOW])
        else $error("status did not report the clear pin low");

endmodule
`default_nettype wire

// *** sdir_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdir_host_model (
    input wire logic core_clk,
    output logic [7:0] pins
);
    initial pins = sdir_pkg::SDIR_PIN_IDLE;

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic set_pin(input int idx, input logic v);
        pins[idx] <= v;
    endtask

    // one strobe period is 25 cycles, 125 ns; data moves only in the idle phase
    task automatic send_word(input logic [11:0] w, input int idx);
        for (int i = 11; i >= 0; i--) begin
            pins[sdir_pkg::SDIR_PIN_DATA] <= w[i];
            cyc(12);
            pins[idx] <= ~pins[idx];
            cyc(13);
            pins[idx] <= ~pins[idx];
        end
        cyc(1);
        // released line shows the inverse, not a stale bit
        pins[sdir_pkg::SDIR_PIN_DATA] <= ~w[0];
    endtask

    // called after a full word, and also with 0 or 1 bits shifted since the last transfer
    task automatic transfer();
        pins[sdir_pkg::SDIR_PIN_LOAD_A_N] <= 1'h0;
        pins[sdir_pkg::SDIR_PIN_LOAD_B_N] <= 1'h0;
        cyc(8);
        pins[sdir_pkg::SDIR_PIN_LOAD_A_N] <= 1'h1;
        pins[sdir_pkg::SDIR_PIN_LOAD_B_N] <= 1'h1;
        cyc(6);
    endtask
endmodule
`default_nettype wire

// *** sdir_serial_dac_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdir_serial_dac_regs_tb;
    logic core_clk = 1'h0;
    logic rst_n = 1'h0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [11:0] dac_code;
    logic dac_polarity;
    logic [10:0] dac_magnitude;
    logic [11:0] code_out_data;
    logic code_out_valid;
    logic code_out_ready = 1'h0;
    logic hold_ready = 1'h0;
    wire logic [7:0] pins;
    logic [11:0] exp_q[$];
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;
    int strobe_idx[4] = '{1, 2, 3, 4};

    always #2.5 core_clk = ~core_clk;

    sdir_host_model u_host (.core_clk(core_clk), .pins(pins));

    sdir_serial_dac_regs u_dut (
        .core_clk(core_clk), .rst_n(rst_n),
        .serial_bit_in(pins[sdir_pkg::SDIR_PIN_DATA]),
        .shift_strobe_rise_a(pins[sdir_pkg::SDIR_PIN_RISE_A]),
        .shift_strobe_rise_b(pins[sdir_pkg::SDIR_PIN_RISE_B]),
        .shift_strobe_fall_n(pins[sdir_pkg::SDIR_PIN_FALL_N]),
        .shift_strobe_rise_c(pins[sdir_pkg::SDIR_PIN_RISE_C]),
        .transfer_enable_a_n(pins[sdir_pkg::SDIR_PIN_LOAD_A_N]),
        .transfer_enable_b_n(pins[sdir_pkg::SDIR_PIN_LOAD_B_N]),
        .input_reg_zero_n(pins[sdir_pkg::SDIR_PIN_ZERO_N]),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .dac_code(dac_code), .dac_polarity(dac_polarity), .dac_magnitude(dac_magnitude),
        .code_out_data(code_out_data), .code_out_valid(code_out_valid),
        .code_out_ready(code_out_ready)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        if (err_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'h0);
        rd = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        @(posedge core_clk);
    endtask

    always @(posedge core_clk) begin
        code_out_ready <= hold_ready ? 1'h0 : 1'($urandom_range(1));
    end

    // each accepted stream word must match the oldest noted transfer
    always @(posedge core_clk) begin
        if (rst_n && code_out_valid === 1'h1 && code_out_ready === 1'h1) begin
            if (exp_q.size() > 0)
                check(code_out_data, exp_q.pop_front());
            else
                check(code_out_data, 32'hFFFFFFFF);
        end
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles > 20000) begin
            err_count++;
            give_verdict();
        end
    end

    initial begin
        logic [31:0] rd;
        logic [11:0] w;
        void'($urandom(41513));
        repeat (16) @(posedge core_clk);
        rst_n <= 1'h1;
        @(posedge core_clk);
        check(dac_code, 32'h0);
        bus(1'h0, sdir_pkg::SDIR_ADDR_CTRL, 32'h0, rd);
        check(rd, 32'h3);
        bus(1'h1, 4'h1, 32'hFFFFFFFF, rd);
        bus(1'h0, 4'h1, 32'h0, rd);
        check(rd, 32'h0);
        for (int s = 0; s < 4; s++) begin
            w = 12'($urandom);
            u_host.send_word(w, strobe_idx[s]);
            bus(1'h0, sdir_pkg::SDIR_ADDR_SHIFT, 32'h0, rd);
            check(rd, {12'h000, 4'hC, 4'h0, w});
            exp_q.push_back(w);
            u_host.transfer();
            check(dac_code, w);
            check({dac_polarity, dac_magnitude}, w);
        end
        exp_q.push_back(w);
        u_host.transfer();
        check(dac_code, w);
        bus(1'h0, sdir_pkg::SDIR_ADDR_SHIFT, 32'h0, rd);
        check(rd[11:0], w);
        u_host.set_pin(sdir_pkg::SDIR_PIN_ZERO_N, 1'h0);
        #1;
        check(dac_code, 32'h0);
        @(posedge core_clk);
        u_host.transfer();
        check(dac_code, 32'h0);
        bus(1'h0, sdir_pkg::SDIR_ADDR_STATUS, 32'h0, rd);
        check(rd[2], 1'h1);
        check(rd[1], 1'h1);
        bus(1'h0, sdir_pkg::SDIR_ADDR_SHIFT, 32'h0, rd);
        check(rd[11:0], w);
        u_host.set_pin(sdir_pkg::SDIR_PIN_ZERO_N, 1'h1);
        u_host.cyc(4);
        // raising one strobe shifts once; edges under it must not
        u_host.set_pin(sdir_pkg::SDIR_PIN_RISE_B, 1'h1);
        u_host.cyc(6);
        u_host.send_word(~w, sdir_pkg::SDIR_PIN_RISE_A);
        u_host.set_pin(sdir_pkg::SDIR_PIN_RISE_B, 1'h0);
        u_host.cyc(6);
        w = {w[10:0], ~w[0]};
        bus(1'h0, sdir_pkg::SDIR_ADDR_SHIFT, 32'h0, rd);
        check(rd[11:0], w);
        bus(1'h0, sdir_pkg::SDIR_ADDR_STATUS, 32'h0, rd);
        check(rd[0], 1'h1);
        bus(1'h1, sdir_pkg::SDIR_ADDR_STATUS, 32'h1, rd);
        bus(1'h0, sdir_pkg::SDIR_ADDR_STATUS, 32'h0, rd);
        check(rd[0], 1'h0);
        // shifting and loading switched off: a clean edge and a transfer change nothing
        bus(1'h1, sdir_pkg::SDIR_ADDR_CTRL, 32'h0, rd);
        u_host.set_pin(sdir_pkg::SDIR_PIN_RISE_C, 1'h1);
        u_host.cyc(6);
        u_host.set_pin(sdir_pkg::SDIR_PIN_RISE_C, 1'h0);
        u_host.transfer();
        bus(1'h0, sdir_pkg::SDIR_ADDR_SHIFT, 32'h0, rd);
        check(rd[11:0], w);
        check(dac_code, 32'h0);
        bus(1'h1, sdir_pkg::SDIR_ADDR_CTRL, 32'h3, rd);
        // stall the sink until the buffer refuses, then drain with the loads still low
        rd = 32'h0;
        hold_ready <= 1'h1;
        for (int k = 0; k < 3 && rd[3] !== 1'h1; k++) begin
            exp_q.push_back(w);
            u_host.set_pin(sdir_pkg::SDIR_PIN_LOAD_A_N, 1'h0);
            u_host.set_pin(sdir_pkg::SDIR_PIN_LOAD_B_N, 1'h0);
            u_host.cyc(6);
            bus(1'h0, sdir_pkg::SDIR_ADDR_STATUS, 32'h0, rd);
            if (rd[3] !== 1'h1) begin
                u_host.set_pin(sdir_pkg::SDIR_PIN_LOAD_A_N, 1'h1);
                u_host.set_pin(sdir_pkg::SDIR_PIN_LOAD_B_N, 1'h1);
                u_host.cyc(6);
            end
        end
        check(rd[3], 1'h1);
        hold_ready <= 1'h0;
        repeat (80) @(posedge core_clk);
        u_host.set_pin(sdir_pkg::SDIR_PIN_LOAD_A_N, 1'h1);
        u_host.set_pin(sdir_pkg::SDIR_PIN_LOAD_B_N, 1'h1);
        u_host.cyc(6);
        check(exp_q.size(), 32'h0);
        check(dac_code, w);
        give_verdict();
    end
endmodule
`default_nettype wire
